// File: inc/usb_bulk_pkg.sv
`default_nettype none
package usb_bulk_pkg;

    // data path shape
    localparam int BYTE_W     = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW    = 3;
    localparam int CNT_W      = 16;

    // max-packet field layout: multiplier-minus-one above, size below
    localparam int MAXP_MSB = 10;
    localparam int MULT_LSB = 11;
    localparam int MULT_MSB = 15;

    // early de-assert window in bytes
    localparam logic [CNT_W-1:0] EARLY_BYTES = 16'h0010;

    // reset values
    localparam logic [CNT_W-1:0] CNT_RESET  = 16'h0000;
    localparam logic             FLAG_RESET = 1'h0;
    localparam logic             IRQ_N_IDLE = 1'h1;

    // out endpoint control bits and max packet field
    typedef struct packed {
        logic        auto_ready_clear;
        logic        dma_request_enable;
        logic        dma_request_mode;
        logic        early_deassert;
        logic        combine_enable;
        logic        request_stall;
        logic [15:0] max_packet;
    } out_cfg_type;

    // in endpoint control bits and max packet size
    typedef struct packed {
        logic        auto_ready_set;
        logic        dma_request_enable;
        logic        early_deassert;
        logic [10:0] max_packet;
    } in_cfg_type;

    // one-cycle answers sent back toward the link
    typedef struct packed {
        logic ack;
        logic nak;
        logic stall;
    } handshake_type;

endpackage : usb_bulk_pkg
`default_nettype wire

// File: hdl/byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// depth must be a power of two so the pointers wrap by themselves
module byte_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW    = 3
)
(
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    // honest flags straight from the occupancy count
    assign in_ready  = count_reg != FULL_COUNT;
    assign out_valid = count_reg != '0;
    assign out_data  = mem_reg[rd_ptr_reg];

    // storage, one flop row per entry
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        always_ff @(posedge clk)
        begin
            if (push && wr_ptr_reg == AW'(i))
                mem_reg[i] <= in_data;
        end
    end

    // pointers and count; flush empties without touching storage
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else if (flush)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(pop);
            count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : byte_fifo
`default_nettype wire

// File: hdl/usb_bulk_endpoint_dma_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module usb_bulk_endpoint_dma_ctrl
    import usb_bulk_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [BYTE_W-1:0] rx_data,
    input  wire logic              rx_valid,
    output logic                   rx_ready,
    input  wire logic              rx_end,
    output handshake_type          handshake,
    output logic                   data_toggle,
    input  wire out_cfg_type       out_cfg,
    input  wire logic              clear_ready,
    input  wire logic              clear_stall_sent,
    input  wire logic              reset_data_toggle,
    input  wire logic              fifo_flush,
    output logic                   out_packet_ready,
    output logic                   stall_sent_flag,
    output logic [CNT_W-1:0]       out_byte_count_reg,
    output logic                   out_irq,
    output logic [BYTE_W-1:0]      rd_data,
    output logic                   rd_valid,
    input  wire logic              rd_ready,
    output logic                   out_dma_req,
    input  wire in_cfg_type        in_cfg,
    input  wire logic              in_fifo_room,
    input  wire logic              in_load,
    input  wire logic              in_ready_set,
    input  wire logic              in_packet_sent,
    output logic                   in_packet_ready,
    output logic                   in_dma_req,
    input  wire logic              dma_start,
    input  wire logic [CNT_W-1:0]  dma_total_len,
    input  wire logic              dma_irq_ack,
    output logic                   dma_done_irq_n
);
    logic             fifo_in_ready;
    logic             in_pkt_reg;
    logic             drop_reg;
    logic [CNT_W-1:0] pkt_cnt_reg;
    logic [CNT_W-1:0] acc_reg;
    logic             full_reg;
    logic [CNT_W-1:0] unload_cnt_reg;
    logic [CNT_W-1:0] in_cnt_reg;
    logic             dma_busy_reg;
    logic [CNT_W-1:0] dma_cnt_reg;
    handshake_type    hs_next;

    // sizes derived from the max packet field
    wire [CNT_W-1:0] maxp      = {5'h00, out_cfg.max_packet[MAXP_MSB:0]};
    wire [CNT_W-1:0] mult      = {11'h000, out_cfg.max_packet[MULT_MSB:MULT_LSB]} + 16'h0001;
    wire [CNT_W-1:0] target    = 16'(maxp * mult);
    wire [CNT_W-1:0] in_maxp   = {5'h00, in_cfg.max_packet};

    // drop decision frozen at packet start so a clear mid-packet cannot split it
    wire drop_now  = in_pkt_reg ? drop_reg : (out_cfg.request_stall | out_packet_ready);
    wire push      = rx_valid & ~drop_now;
    wire byte_in   = push & fifo_in_ready;
    assign rx_ready = drop_now | fifo_in_ready;

    // end-of-packet decode
    wire             good_end  = rx_end & ~drop_now;
    wire [CNT_W-1:0] acc_total = acc_reg + pkt_cnt_reg;
    wire             full_pkt  = pkt_cnt_reg == maxp;
    wire             more      = out_cfg.combine_enable & full_pkt & (acc_total < target);
    wire             ready_set = good_end & ~more;
    wire             stall_end = rx_end & drop_now & out_cfg.request_stall;
    wire [CNT_W-1:0] full_size = out_cfg.combine_enable ? target : maxp;

    // unload side: a read counts toward the held packet only while out_packet_ready is set
    wire             rd_fire   = rd_valid & rd_ready;
    wire [CNT_W-1:0] remaining = out_byte_count_reg - unload_cnt_reg;
    wire auto_clr  = out_cfg.auto_ready_clear & full_reg & out_packet_ready & rd_fire
                   & (unload_cnt_reg + 16'h0001 == out_byte_count_reg);
    wire ready_clr = clear_ready | fifo_flush | auto_clr;

    // out request: mode one only for full packets; mode zero also for a held short packet
    wire out_req_next = out_cfg.dma_request_enable & out_packet_ready
                      & (~out_cfg.dma_request_mode | full_reg)
                      & (remaining != CNT_RESET)
                      & ~(out_cfg.early_deassert & remaining <= EARLY_BYTES);

    // in side: auto-set on the byte that completes a max packet
    wire auto_hit = in_cfg.auto_ready_set & in_load
                  & (in_cnt_reg + 16'h0001 == in_maxp);
    wire in_set   = in_ready_set | auto_hit;
    wire [CNT_W-1:0] in_left = in_maxp - in_cnt_reg;
    wire in_req_next = in_cfg.dma_request_enable & in_fifo_room & ~in_packet_ready
                     & (in_cnt_reg < in_maxp)
                     & ~(in_cfg.early_deassert & in_left <= EARLY_BYTES);

    // transfer completion counter for the active-low done line
    wire beat      = dma_busy_reg & (in_load | rd_fire);
    wire beat_last = beat & (dma_cnt_reg + 16'h0001 == dma_total_len);

    assign hs_next.ack   = good_end;
    assign hs_next.nak   = rx_end & drop_now & ~out_cfg.request_stall;
    assign hs_next.stall = stall_end;

    // small buffer between link and unload port; full stalls the link
    byte_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .flush     (fifo_flush),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_data),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    // receive tracking and handshakes
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            in_pkt_reg  <= FLAG_RESET;
            drop_reg    <= FLAG_RESET;
            pkt_cnt_reg <= CNT_RESET;
            acc_reg     <= CNT_RESET;
            handshake   <= '0;
            out_irq     <= FLAG_RESET;
            data_toggle <= FLAG_RESET;
        end
        else
        begin
            in_pkt_reg  <= rx_end ? 1'h0 : (in_pkt_reg | rx_valid);
            drop_reg    <= drop_now;
            pkt_cnt_reg <= rx_end ? CNT_RESET : pkt_cnt_reg + 16'(byte_in);
            acc_reg     <= (fifo_flush | ready_set) ? CNT_RESET : (more ? acc_total : acc_reg);
            handshake   <= hs_next;
            out_irq     <= ready_set | stall_end;
            data_toggle <= reset_data_toggle ? 1'h0 : (data_toggle ^ good_end);
        end
    end

    // packet-ready, size, stall flag; a set wins over a same-cycle clear
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_packet_ready   <= FLAG_RESET;
            out_byte_count_reg <= CNT_RESET;
            full_reg           <= FLAG_RESET;
            stall_sent_flag    <= FLAG_RESET;
            unload_cnt_reg     <= CNT_RESET;
        end
        else
        begin
            out_packet_ready   <= ready_set | (out_packet_ready & ~ready_clr);
            out_byte_count_reg <= ready_set ? acc_total : out_byte_count_reg;
            full_reg           <= ready_set ? (acc_total == full_size) : full_reg;
            stall_sent_flag    <= stall_end | (stall_sent_flag & ~clear_stall_sent);
            unload_cnt_reg     <= (ready_set | ready_clr) ? CNT_RESET
                                : unload_cnt_reg + 16'(rd_fire & out_packet_ready);
        end
    end

    // in endpoint counters and registered request lines
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            in_cnt_reg      <= CNT_RESET;
            in_packet_ready <= FLAG_RESET;
            in_dma_req      <= FLAG_RESET;
            out_dma_req     <= FLAG_RESET;
        end
        else
        begin
            in_cnt_reg      <= in_set ? CNT_RESET : in_cnt_reg + 16'(in_load);
            in_packet_ready <= in_set | (in_packet_ready & ~in_packet_sent);
            in_dma_req      <= in_req_next;
            out_dma_req     <= out_req_next;
        end
    end

    // completion tracking; start or ack releases the interrupt
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dma_busy_reg   <= FLAG_RESET;
            dma_cnt_reg    <= CNT_RESET;
            dma_done_irq_n <= IRQ_N_IDLE;
        end
        else
        begin
            dma_busy_reg   <= dma_start | (dma_busy_reg & ~beat_last);
            dma_cnt_reg    <= dma_start ? CNT_RESET : dma_cnt_reg + 16'(beat);
            dma_done_irq_n <= ~beat_last & (dma_start | dma_irq_ack | dma_done_irq_n);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_stall_pkt;
        rx_end && drop_now && out_cfg.request_stall;
    endsequence

    sequence s_held_mode0;
        out_packet_ready && out_cfg.dma_request_enable && !out_cfg.dma_request_mode
        && remaining != CNT_RESET && !(out_cfg.early_deassert && remaining <= EARLY_BYTES);
    endsequence

    a_ready_on_rx: assert property (ready_set |=> out_packet_ready && out_irq)
        else $error("out packet ready not set after accepted packet");
    a_combine_hold: assert property (good_end && more |=> !out_packet_ready)
        else $error("ready set while combining packets");
    a_stall_sent: assert property (s_stall_pkt |=> stall_sent_flag && handshake.stall)
        else $error("stall not answered or flag not set");
    a_in_req_drop: assert property (in_packet_ready |=> !in_dma_req)
        else $error("in request high while in packet ready");
    a_auto_set: assert property (auto_hit |=> in_packet_ready ##1 !in_dma_req)
        else $error("auto-set did not mark in packet ready");
    a_mode0_req: assert property (s_held_mode0 |=> out_dma_req)
        else $error("mode zero request missing for held packet");
    a_mode1_short: assert property (out_cfg.dma_request_mode && !full_reg |=> !out_dma_req)
        else $error("mode one request for short packet");
    a_auto_clear: assert property (auto_clr && !ready_set |=> !out_packet_ready)
        else $error("auto-clear did not drop out packet ready");
    a_done_irq: assert property (beat_last |=> !dma_done_irq_n [*1] ##1 1'h1)
        else $error("done interrupt not asserted at last beat");
    a_req_idle: assert property (!out_packet_ready |=> !out_dma_req)
        else $error("out request without held packet");

endmodule : usb_bulk_endpoint_dma_ctrl
`default_nettype wire

// File: sim/out_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the dma engine unloading the out fifo
module out_dma_model
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       req,
    input  wire logic       valid,
    input  wire logic [7:0] data,
    input  wire logic       en,
    input  wire logic       slow,
    output logic            rd_ready,
    output logic [7:0]      last_byte,
    output int              taken
);
    // reads only on request, so nothing is lost before ready is set
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_ready <= 1'h0;
            last_byte <= 8'h00;
            taken <= 0;
        end
        else
        begin
            if (rd_ready && valid)
            begin
                taken <= taken + 1;
                last_byte <= data;
            end
            rd_ready <= en && req && !(slow && rd_ready);
        end
    end
endmodule : out_dma_model
`default_nettype wire

// File: sim/usb_bulk_endpoint_dma_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
`define WAITC(c) for (int k = 0; k < 40 && !(c); k++) @(posedge clk) #1;
module usb_bulk_endpoint_dma_ctrl_tb;
    import usb_bulk_pkg::*;
    logic          clk = 1'b0;
    logic          rst_b = 1'b0;
    logic [7:0]    rx_data = 8'h00;
    logic          rx_valid = 1'b0;
    logic          rx_ready, rx_end = 1'b0;
    handshake_type handshake, hs;
    logic          data_toggle, irq;
    out_cfg_type   ocfg = '0;
    in_cfg_type    icfg = '0;
    logic          clear_ready = 1'b0, clear_stall_sent = 1'b0;
    logic          reset_data_toggle = 1'b0, fifo_flush = 1'b0;
    logic          out_packet_ready, stall_sent_flag, out_irq;
    logic [15:0]   out_byte_count_reg;
    logic [7:0]    rd_data, last_byte;
    logic          rd_valid, rd_ready, out_dma_req, in_packet_ready, in_dma_req;
    logic          in_fifo_room = 1'b0, in_load = 1'b0;
    logic          in_ready_set = 1'b0, in_packet_sent = 1'b0;
    logic          dma_start = 1'b0, dma_irq_ack = 1'b0, dma_done_irq_n;
    logic [15:0]   dma_total_len = 16'h0000;
    logic          pen = 1'b1, pslow = 1'b0;
    int            taken, fails = 0, samples_checked = 0, cyc = 0;

    usb_bulk_endpoint_dma_ctrl dut (.clk(clk), .rst_b(rst_b), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_end(rx_end), .handshake(handshake),
        .data_toggle(data_toggle), .out_cfg(ocfg), .clear_ready(clear_ready),
        .clear_stall_sent(clear_stall_sent), .reset_data_toggle(reset_data_toggle),
        .fifo_flush(fifo_flush), .out_packet_ready(out_packet_ready),
        .stall_sent_flag(stall_sent_flag), .out_byte_count_reg(out_byte_count_reg),
        .out_irq(out_irq), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .out_dma_req(out_dma_req), .in_cfg(icfg), .in_fifo_room(in_fifo_room),
        .in_load(in_load), .in_ready_set(in_ready_set), .in_packet_sent(in_packet_sent),
        .in_packet_ready(in_packet_ready), .in_dma_req(in_dma_req), .dma_start(dma_start),
        .dma_total_len(dma_total_len), .dma_irq_ack(dma_irq_ack),
        .dma_done_irq_n(dma_done_irq_n));

    out_dma_model partner (.clk(clk), .rst_b(rst_b), .req(out_dma_req), .valid(rd_valid),
        .data(rd_data), .en(pen), .slow(pslow), .rd_ready(rd_ready),
        .last_byte(last_byte), .taken(taken));

    // 25 ns period clock
    always #12.5 clk = ~clk;

    // hang guard, well above the hundred or so cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            end_of_test();
        end
    end

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge clk) #1;
        s = 1'b0;
    endtask : pulse

    // one packet of n bytes, then capture the handshake edge
    task automatic send(input int n, input logic [7:0] b0);
        for (int i = 0; i < n; i++)
        begin
            rx_valid = 1'b1;
            rx_data = b0 + 8'(i);
            while (!rx_ready) @(posedge clk) #1;
            @(posedge clk) #1;
        end
        rx_valid = 1'b0;
        rx_end = 1'b1;
        @(posedge clk) #1;
        rx_end = 1'b0;
        hs = handshake;
        irq = out_irq;
    endtask : send

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    // main sequence
    initial
    begin
        ocfg.auto_ready_clear = 1'b1;
        ocfg.dma_request_enable = 1'b1;
        ocfg.max_packet = 16'h0004;
        repeat (5) @(posedge clk);
        #1 rst_b = 1'b1;
        `CHK("ready", 1'b0, out_packet_ready)
        `CHK("out_req", 1'b0, out_dma_req)
        `CHK("in_req", 1'b0, in_dma_req)
        `CHK("irq_n", 1'b1, dma_done_irq_n)
        // full packet, mode 0, dma unloads, auto-clear
        send(4, 8'ha0);
        `CHK("ack", 1'b1, hs.ack)
        `CHK("irq", 1'b1, irq)
        `CHK("ready", 1'b1, out_packet_ready)
        `CHK("count", 16'h0004, out_byte_count_reg)
        `CHK("toggle", 1'b1, data_toggle)
        `WAITC(out_dma_req)
        `CHK("out_req", 1'b1, out_dma_req)
        `WAITC(taken == 4)
        repeat (2) @(posedge clk) #1;
        `CHK("last", 8'ha3, last_byte)
        `CHK("ready", 1'b0, out_packet_ready)
        `CHK("out_req", 1'b0, out_dma_req)
        pulse(reset_data_toggle);
        `CHK("toggle", 1'b0, data_toggle)
        // short packet in mode 1, then switch to mode 0
        ocfg.dma_request_mode = 1'b1;
        pslow = 1'b1;
        send(2, 8'hb0);
        `CHK("irq", 1'b1, irq)
        repeat (3) @(posedge clk) #1;
        `CHK("out_req", 1'b0, out_dma_req)
        `CHK("ready", 1'b1, out_packet_ready)
        // a packet arriving while one is still held is refused
        send(1, 8'hbf);
        `CHK("nak", 1'h1, hs.nak)
        `CHK("ack", 1'h0, hs.ack)
        ocfg.dma_request_mode = 1'b0;
        `WAITC(out_dma_req)
        `CHK("out_req", 1'b1, out_dma_req)
        `WAITC(taken == 6)
        `CHK("last", 8'hb1, last_byte)
        `CHK("ready", 1'b1, out_packet_ready)
        pulse(clear_ready);
        `CHK("ready", 1'b0, out_packet_ready)
        // combining two packets of size 2 into one of 4
        ocfg.combine_enable = 1'b1;
        ocfg.max_packet = 16'h0802;
        send(2, 8'hc0);
        `CHK("ack", 1'b1, hs.ack)
        `CHK("ready", 1'b0, out_packet_ready)
        send(2, 8'hc2);
        `CHK("ready", 1'b1, out_packet_ready)
        `CHK("count", 16'h0004, out_byte_count_reg)
        `WAITC(taken == 10)
        `CHK("last", 8'hc3, last_byte)
        pulse(clear_ready);
        // a full packet closed early by a zero-length one
        send(2, 8'hc4);
        @(posedge clk) #1;
        send(0, 8'h00);
        `CHK("ack", 1'h1, hs.ack)
        `CHK("ready", 1'h1, out_packet_ready)
        `CHK("count", 16'h0002, out_byte_count_reg)
        `WAITC(taken == 12)
        `CHK("last", 8'hc5, last_byte)
        pulse(clear_ready);
        // held short packet discarded by flush
        ocfg.combine_enable = 1'b0;
        ocfg.max_packet = 16'h0004;
        ocfg.dma_request_mode = 1'b1;
        send(2, 8'hd0);
        pulse(fifo_flush);
        pulse(clear_ready);
        `CHK("rd_valid", 1'b0, rd_valid)
        ocfg.dma_request_mode = 1'b0;
        // stall twice, toggle untouched
        ocfg.request_stall = 1'b1;
        for (int r = 0; r < 2; r++)
        begin
            send(2, 8'he0);
            `CHK("stall", 1'b1, hs.stall)
            `CHK("ack", 1'b0, hs.ack)
            `CHK("irq", 1'b1, irq)
            `CHK("stall_flag", 1'b1, stall_sent_flag)
            `CHK("ready", 1'b0, out_packet_ready)
            pulse(clear_stall_sent);
            `CHK("stall_flag", 1'b0, stall_sent_flag)
        end
        `CHK("toggle", 1'h0, data_toggle)
        // re-enable: one packet acked, then restart the toggle
        ocfg.request_stall = 1'h0;
        send(1, 8'hf0);
        `CHK("ack", 1'h1, hs.ack)
        `CHK("toggle", 1'h1, data_toggle)
        pulse(fifo_flush);
        pulse(reset_data_toggle);
        `CHK("toggle", 1'b0, data_toggle)
        // in side: request, auto-set, dma completion
        icfg.auto_ready_set = 1'b1;
        icfg.dma_request_enable = 1'b1;
        icfg.max_packet = 11'h004;
        in_fifo_room = 1'b1;
        dma_total_len = 16'h0004;
        pulse(dma_start);
        `WAITC(in_dma_req)
        `CHK("in_req", 1'b1, in_dma_req)
        in_load = 1'b1;
        repeat (4) @(posedge clk) #1;
        in_load = 1'b0;
        repeat (2) @(posedge clk) #1;
        `CHK("in_ready", 1'b1, in_packet_ready)
        `CHK("in_req", 1'b0, in_dma_req)
        `CHK("irq_n", 1'b0, dma_done_irq_n)
        pulse(dma_irq_ack);
        `CHK("irq_n", 1'b1, dma_done_irq_n)
        pulse(in_packet_sent);
        `CHK("in_ready", 1'b0, in_packet_ready)
        `WAITC(in_dma_req)
        `CHK("in_req", 1'b1, in_dma_req)
        pulse(in_ready_set);
        `CHK("in_ready", 1'b1, in_packet_ready)
        repeat (2) @(posedge clk) #1;
        `CHK("in_req", 1'b0, in_dma_req)
        // early de-assert: request falls with 16 bytes still to load
        icfg.early_deassert = 1'h1;
        icfg.max_packet = 11'h014;
        pulse(in_packet_sent);
        `WAITC(in_dma_req)
        `CHK("in_req", 1'h1, in_dma_req)
        in_load = 1'h1;
        repeat (4) @(posedge clk) #1;
        in_load = 1'h0;
        repeat (2) @(posedge clk) #1;
        `CHK("in_req", 1'h0, in_dma_req)
        `CHK("in_ready", 1'h0, in_packet_ready)
        end_of_test();
    end
endmodule : usb_bulk_endpoint_dma_ctrl_tb
`default_nettype wire
